// ===== shared/cxr_params.svh
// offsets, indices, field positions and reset values of the register bank
`ifndef CXR_PARAMS_SVH
`define CXR_PARAMS_SVH
`define CXR_OFS_INDEX      2'h0
`define CXR_OFS_DATA       2'h1
`define CXR_IDX_EXT        5'h17
`define CXR_IDX_CAP_HIGH   5'h1e
`define CXR_IDX_CAP_LOW    5'h1f
`define CXR_X_LINE_L       5'h00
`define CXR_X_LINE_R       5'h01
`define CXR_X_MIC_L        5'h02
`define CXR_X_MIC_R        5'h03
`define CXR_X_MIX_CTL      5'h04
`define CXR_X_LAST_RW      5'h11
`define CXR_X_VERSION      5'h19
`define CXR_RST_CAP        8'h00
`define CXR_RST_LINE       8'he8
`define CXR_RST_MIC        8'hcf
`define CXR_RST_PLAIN      8'h00
`define CXR_BIT_ACCESS_EN  3
`define CXR_BIT_XA4        2
`define CXR_BIT_FREEZE     0
`define CXR_BIT_FM_REMAP   2
`define CXR_BIT_WT_RMD     3
`define CXR_MODE3          2'h3
`endif

// ===== shared/cxr_pkg.sv
// types of the register bank
package cxr_pkg;
  typedef struct packed {
    logic       out_mute;
    logic       in_mute;
    logic       bypass_mute;
    logic [4:0] gain;
  } cxr_line_t;
  typedef struct packed {
    logic       in_mute;
    logic       out_mute;
    logic       boost;
    logic [4:0] gain;
  } cxr_mic_t;
  typedef enum logic [0:0] {
    CXR_EXT_ADDR = 1'b0,
    CXR_EXT_DATA = 1'b1
  } cxr_ext_role_t;
endpackage : cxr_pkg

// ===== hdl/cxr_regs.sv
// codec indexed and extended register bank
`include "cxr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cxr_regs
  import cxr_pkg::*;
#(
  parameter logic [7:0] VERSION_ID = 8'h5a  // arbitrary value
)(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic [1:0] bus_addr,
  input  wire logic       bus_cs,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  input  wire logic [7:0] bus_wdata,
  input  wire logic [1:0] codec_mode,
  output logic      [7:0] bus_rdata,
  output logic      [7:0] index_port,
  output logic     [15:0] capture_base,
  output logic            adpcm_capture_freeze,
  output cxr_line_t       left_line,
  output cxr_line_t       right_line,
  output cxr_mic_t        left_mic,
  output cxr_mic_t        right_mic,
  output logic            line_remapped
);

  ////////////////////////////////////////////////////////////////////////
  // decode

  logic [7:0]    index_q;
  logic [7:0]    ext_addr_q;
  cxr_ext_role_t role_q;
  logic [7:0]    cap_high_q;
  logic [7:0]    cap_low_q;
  logic [7:0]    xreg_q [0:17];
  logic          wr_index;
  logic          wr_data;
  logic          mode3;
  logic [4:0]    ext_index;
  logic [4:0]    indirect_index;

  function automatic logic [4:0] ext_idx_of(input logic [7:0] v);
    ext_idx_of = {v[`CXR_BIT_XA4], v[7:4]};
  endfunction : ext_idx_of

  assign mode3          = (codec_mode == `CXR_MODE3);
  assign indirect_index = index_q[4:0];
  assign ext_index      = ext_idx_of(ext_addr_q);

  always_comb
  begin
    wr_index = 1'b0;
    wr_data  = 1'b0;
    if (bus_cs && bus_wr && bus_addr == `CXR_OFS_INDEX)
      wr_index = 1'b1;
    else if (bus_cs && bus_wr && bus_addr == `CXR_OFS_DATA)
      wr_data = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // index port

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      index_q <= 8'h00;
    else if (clk_en && wr_index)
      index_q <= bus_wdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // extended address / data role

  logic ext_sel;
  logic ext_data_acc;
  assign ext_sel      = (indirect_index == `CXR_IDX_EXT);
  assign ext_data_acc = ext_sel && mode3 && (role_q == CXR_EXT_DATA);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      role_q     <= CXR_EXT_ADDR;
      ext_addr_q <= 8'h00;
    end
    else if (clk_en)
    begin
      if (wr_index)
        role_q <= CXR_EXT_ADDR;
      else if (wr_data && ext_sel && !ext_data_acc)
      begin
        ext_addr_q <= bus_wdata;
        if (mode3 && bus_wdata[`CXR_BIT_ACCESS_EN])
          role_q <= CXR_EXT_DATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture base

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cap_high_q <= `CXR_RST_CAP;
      cap_low_q  <= `CXR_RST_CAP;
    end
    else if (clk_en && wr_data)
    begin
      if (indirect_index == `CXR_IDX_CAP_HIGH)
        cap_high_q <= bus_wdata;
      else if (indirect_index == `CXR_IDX_CAP_LOW)
        cap_low_q <= bus_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // extended registers

  genvar gi;
  generate
    for (gi = 0; gi <= 17; gi = gi + 1)
    begin : g_xreg
      localparam logic [7:0] RST_V =
        (gi <= 1) ? `CXR_RST_LINE :
        (gi <= 3) ? `CXR_RST_MIC  : `CXR_RST_PLAIN;
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          xreg_q[gi] <= RST_V;
        else if (clk_en && wr_data && ext_data_acc &&
                 ext_index == 5'(gi))
          xreg_q[gi] <= bus_wdata;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read data

  logic [7:0] rd_d;
  always_comb
  begin
    rd_d = 8'h00;
    if (bus_addr == `CXR_OFS_INDEX)
      rd_d = index_q;
    else if (bus_addr == `CXR_OFS_DATA)
    begin
      if (ext_data_acc)
      begin
        if (ext_index <= `CXR_X_LAST_RW)
          rd_d = xreg_q[ext_index];
        else if (ext_index == `CXR_X_VERSION)
          rd_d = VERSION_ID;
        else
          rd_d = 8'h00;
      end
      else if (ext_sel)
        rd_d = {ext_addr_q[7:2], 1'b0, ext_addr_q[0]};
      else if (indirect_index == `CXR_IDX_CAP_HIGH)
        rd_d = cap_high_q;
      else if (indirect_index == `CXR_IDX_CAP_LOW)
        rd_d = cap_low_q;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bus_rdata <= 8'h00;
    else if (clk_en && bus_cs && bus_rd)
      bus_rdata <= rd_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // control outputs

  assign index_port           = index_q;
  assign capture_base         = {cap_high_q, cap_low_q};
  assign adpcm_capture_freeze = ext_addr_q[`CXR_BIT_FREEZE];
  assign left_line            = cxr_line_t'(xreg_q[`CXR_X_LINE_L]);
  assign right_line           = cxr_line_t'(xreg_q[`CXR_X_LINE_R]);
  assign left_mic             = cxr_mic_t'(xreg_q[`CXR_X_MIC_L]);
  assign right_mic            = cxr_mic_t'(xreg_q[`CXR_X_MIC_R]);
  assign line_remapped = xreg_q[`CXR_X_MIX_CTL][`CXR_BIT_FM_REMAP] ||
                         !xreg_q[`CXR_X_MIX_CTL][`CXR_BIT_WT_RMD];

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_index_clears_en: assert property (
    @(posedge clk) disable iff (rst)
    clk_en && wr_index |=> role_q == CXR_EXT_ADDR)
    else $error("index write did not clear access enable");
  a_en_needs_mode3: assert property (
    @(posedge clk) disable iff (rst)
    clk_en && wr_data && ext_sel && !mode3 && role_q == CXR_EXT_ADDR
    |=> role_q == CXR_EXT_ADDR)
    else $error("extended access outside mode three");
  a_en_sets_data: assert property (
    @(posedge clk) disable iff (rst)
    clk_en && wr_data && ext_sel && mode3 && !ext_data_acc &&
    bus_wdata[3] |=> role_q == CXR_EXT_DATA)
    else $error("access enable did not switch role");
  a_cap_high_hold: assert property (
    @(posedge clk) disable iff (rst)
    clk_en && wr_data && indirect_index == 5'h1e
    |=> capture_base[15:8] == $past(bus_wdata))
    else $error("capture high byte not stored");
  a_cap_low_hold: assert property (
    @(posedge clk) disable iff (rst)
    clk_en && wr_data && indirect_index == 5'h1f
    |=> capture_base[7:0] == $past(bus_wdata))
    else $error("capture low byte not stored");
  a_cap_stable: assert property (
    @(posedge clk) disable iff (rst)
    !(clk_en && wr_data && indirect_index[4:1] == 4'hf)
    |=> $stable(capture_base))
    else $error("capture base changed without write");
  a_line_write: assert property (
    @(posedge clk) disable iff (rst)
    clk_en && wr_data && ext_data_acc && ext_index == 5'h00
    |=> left_line == $past(bus_wdata))
    else $error("left line register not written");
  a_right_line_input_write: assert property (
    @(posedge clk) disable iff (rst)
    clk_en && wr_data && ext_data_acc && ext_index == 5'h01
    |=> right_line == $past(bus_wdata))
    else $error("right line register not written");
  a_lmic_write: assert property (
    @(posedge clk) disable iff (rst)
    clk_en && wr_data && ext_data_acc && ext_index == 5'h02
    |=> left_mic == $past(bus_wdata))
    else $error("left mic register not written");
  a_rmic_write: assert property (
    @(posedge clk) disable iff (rst)
    clk_en && wr_data && ext_data_acc && ext_index == 5'h03
    |=> right_mic == $past(bus_wdata))
    else $error("right mic register not written");
  a_rsvd_no_change: assert property (
    @(posedge clk) disable iff (rst)
    wr_data && ext_data_acc && ext_index >= 5'h12 && ext_index <= 5'h18
    |=> $stable(left_mic) && $stable(right_line))
    else $error("reserved index altered state");
  a_rsvd_read: assert property (
    @(posedge clk) disable iff (rst)
    clk_en && bus_cs && bus_rd && bus_addr == 2'h1 && ext_data_acc &&
    ext_index >= 5'h12 && ext_index <= 5'h18 |=> bus_rdata == 8'h00)
    else $error("reserved index read not zero");
  a_version_read: assert property (
    @(posedge clk) disable iff (rst)
    clk_en && bus_cs && bus_rd && bus_addr == 2'h1 && ext_data_acc &&
    ext_index == 5'h19 |=> bus_rdata == VERSION_ID)
    else $error("version read mismatch");
  a_read_cap: assert property (
    @(posedge clk) disable iff (rst)
    clk_en && bus_cs && bus_rd && bus_addr == 2'h1 &&
    indirect_index == 5'h1e |=> bus_rdata == $past(cap_high_q))
    else $error("capture high read mismatch");
  a_index_store: assert property (
    @(posedge clk) disable iff (rst)
    clk_en && wr_index |=> index_port == $past(bus_wdata))
    else $error("index port not stored");
  a_rdata_hold: assert property (
    @(posedge clk) disable iff (rst)
    !(clk_en && bus_cs && bus_rd) |=> $stable(bus_rdata))
    else $error("read data changed without read");
  a_freeze_hold: assert property (
    @(posedge clk) disable iff (rst)
    !clk_en |=> $stable(index_port) && $stable(capture_base))
    else $error("state changed while clock enable low");

endmodule : cxr_regs
`default_nettype wire

// ===== dv/cxr_host.sv
// host model issuing index and data port cycles
`timescale 1ns/1ps
`default_nettype none
module cxr_host (
  input  wire logic       clk,
  input  wire logic [7:0] bus_rdata,
  output logic      [1:0] bus_addr,
  output logic            bus_cs,
  output logic            bus_wr,
  output logic            bus_rd,
  output logic      [7:0] bus_wdata
);
  initial
  begin
    {bus_addr, bus_cs, bus_wr, bus_rd, bus_wdata} = '0;
  end
  //////////////////////////////////////////////////////////////////
  // one port cycle, address and data lines show the inverse afterwards, strobes drop to zero
  task automatic cyc(input logic [1:0] a, input logic [7:0] d,
                     input logic w, output logic [7:0] q);
    @(posedge clk);
    #1;
    bus_addr  = a;
    bus_cs    = 1'b1;
    bus_wr    = w;
    bus_rd    = !w;
    bus_wdata = d;
    @(posedge clk);
    #1;
    q = bus_rdata;
    {bus_cs, bus_wr, bus_rd} = 3'h0;
    bus_addr  = ~a;
    bus_wdata = ~d;
  endtask : cyc
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    logic [7:0] q;
    cyc(a, d, 1'b1, q);
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] q);
    cyc(a, 8'h00, 1'b0, q);
  endtask : rd
  // index 17h, then address with enable set and reserved bits zero
  task automatic xsel(input logic [4:0] x);
    wr(2'h0, 8'h17);
    wr(2'h1, {x[3:0], 1'b1, x[4], 2'h0});
  endtask : xsel
endmodule : cxr_host
`default_nettype wire

// ===== dv/codec_extended_register_access_tb_top.sv
// self-checking bench for the codec register bank
`timescale 1ns/1ps
`default_nettype none
module codec_extended_register_access_tb_top
  import cxr_pkg::*;
;
  localparam logic [7:0] VID = 8'h3c; // arbitrary value
  logic        clk;
  logic        rst;
  logic        clk_en;
  logic [1:0]  codec_mode;
  logic [1:0]  bus_addr;
  logic        bus_cs;
  logic        bus_wr;
  logic        bus_rd;
  logic [7:0]  bus_wdata;
  logic [7:0]  bus_rdata;
  logic [7:0]  index_port;
  logic [15:0] capture_base;
  logic        adpcm_capture_freeze;
  logic        line_remapped;
  cxr_line_t   left_line;
  cxr_line_t   right_line;
  cxr_mic_t    left_mic;
  cxr_mic_t    right_mic;
  int          errors;
  int          checks;
  int          cycles;
  logic [7:0]  q;
  cxr_regs #(.VERSION_ID(VID)) i_dut (.clk, .rst, .clk_en,
    .bus_addr, .bus_cs, .bus_wr, .bus_rd, .bus_wdata, .codec_mode,
    .bus_rdata, .index_port, .capture_base, .adpcm_capture_freeze,
    .left_line, .right_line, .left_mic, .right_mic, .line_remapped);
  cxr_host i_host (.clk, .bus_rdata, .bus_addr, .bus_cs, .bus_wr,
    .bus_rd, .bus_wdata);
  always #10 clk = ~clk;
  //////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] s, e);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic t_reset;
    chk("capture_base", capture_base, 16'h0000);
    chk("left_line", left_line, 16'h00e8);
    chk("right_line", right_line, 16'h00e8);
    chk("left_mic", left_mic, 16'h00cf);
    chk("right_mic", right_mic, 16'h00cf);
    chk("line_remapped", line_remapped, 16'h0001);
  endtask : t_reset
  task automatic t_capture;
    i_host.wr(2'h0, 8'h1e);
    i_host.wr(2'h1, 8'ha5);
    i_host.wr(2'h0, 8'h1f);
    chk("index_port", index_port, 16'h001f);
    i_host.wr(2'h1, 8'h3c);
    chk("capture_base", capture_base, 16'ha53c);
    i_host.rd(2'h1, q);
    chk("low_read", q, 16'h003c);
    i_host.wr(2'h0, 8'h1e);
    i_host.rd(2'h1, q);
    chk("high_read", q, 16'h00a5);
  endtask : t_capture
  task automatic t_ext;
    logic [7:0] v [4] = '{8'h55, 8'ha8, 8'h6f, 8'h90};
    codec_mode = 2'h3;
    for (int x = 0; x < 4; x++)
    begin
      i_host.xsel(5'(x));
      i_host.wr(2'h1, v[x]);
    end
    chk("left_line", left_line, 16'h0055);
    chk("right_line", right_line, 16'h00a8);
    chk("left_mic", left_mic, 16'h006f);
    chk("right_mic", right_mic, 16'h0090);
    for (int x = 0; x < 4; x++)
    begin
      i_host.xsel(5'(x));
      i_host.rd(2'h1, q);
      chk("ext_read", q, {8'h00, v[x]});
    end
  endtask : t_ext
  task automatic t_clear;
    i_host.wr(2'h0, 8'h17);
    i_host.wr(2'h1, 8'h01);
    chk("right_mic", right_mic, 16'h0090);
    chk("freeze", adpcm_capture_freeze, 16'h0001);
    i_host.wr(2'h1, 8'h00);
    chk("freeze", adpcm_capture_freeze, 16'h0000);
  endtask : t_clear
  task automatic t_mode;
    codec_mode = 2'h2;
    i_host.xsel(5'h00);
    i_host.wr(2'h1, 8'h00);
    chk("left_line", left_line, 16'h0055);
    codec_mode = 2'h3;
  endtask : t_mode
  task automatic t_reserved;
    i_host.xsel(5'h12);
    i_host.wr(2'h1, 8'hff);
    chk("left_mic", left_mic, 16'h006f);
    i_host.xsel(5'h19);
    i_host.rd(2'h1, q);
    chk("version", q, {8'h00, VID});
    i_host.xsel(5'h11);
    i_host.wr(2'h1, 8'h3f);
    i_host.rd(2'h1, q);
    chk("x17_read", q, 16'h003f);
  endtask : t_reserved
  task automatic t_unmapped;
    i_host.wr(2'h2, 8'h1e);
    i_host.wr(2'h3, 8'h1f);
    chk("index_port", index_port, 16'h0017);
    i_host.rd(2'h2, q);
    chk("port2_read", q, 16'h0000);
  endtask : t_unmapped
  task automatic t_freeze;
    clk_en = 1'b0;
    i_host.wr(2'h0, 8'h1e);
    chk("index_port", index_port, 16'h0017);
    clk_en = 1'b1;
    i_host.wr(2'h0, 8'h17);
    i_host.wr(2'h1, 8'h03);
    chk("freeze", adpcm_capture_freeze, 16'h0001);
    i_host.rd(2'h1, q);
    chk("ext_addr_read", q, 16'h0001);
    i_host.xsel(5'h04);
    i_host.wr(2'h1, 8'h08);
    chk("line_remapped", line_remapped, 16'h0000);
  endtask : t_freeze
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  //////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      errors++;
      report_and_stop();
    end
  end
  initial
  begin
    clk        = 1'b0;
    rst        = 1'b1;
    clk_en     = 1'b1;
    codec_mode = 2'h0;
    errors     = 0;
    checks     = 0;
    cycles     = 0;
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_capture();
    t_ext();
    t_clear();
    t_mode();
    t_reserved();
    t_unmapped();
    t_freeze();
    report_and_stop();
  end
endmodule : codec_extended_register_access_tb_top
`default_nettype wire
